// ===== core/tcr_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// How it works
// R01: with fast clock select at 0 the internal count clock is the cpu tick divided by 2 up to 256.
// R02: with fast clock select at 1 the internal count clock is the oscillator tick, code 000 divides by 128, code 111 by 1.
// R03: in event counting mode the fast clock select bit and the prescale field have no say over counting.
// R04: the counter is an 8-bit register that software reads and writes and that resets to zero.
// R05: outside pwm mode, and always in event counting mode, the counter overflows every 256 counts.
// R06: in pwm mode with the internal count clock, reload control and toggle output select a boundary of 256, 64, 32 or 16 counts.
// R07: for the 64, 32 and 16 boundaries only the low 6, 5 or 4 bits of counter and reload are kept.
// R08: software loads counter and reload with the boundary minus interval times count clock rate.
// R09: with auto reload on, the reload value is copied into the counter at every overflow.
// R10: reload writes go to a holding buffer that moves to the active reload only at overflow.
// R11: pwm mode forces auto reload on, reload control then only picks the boundary.
// R12: at overflow the counter keeps running and a time-out event requests the interrupt.
// R13: with source select on the external input, each falling edge of that input advances the counter.
// R14: the pwm enable bit puts the unit in pwm mode, where reload control and toggle output set the range unless source select picks the external input.
// R15: with auto reload off outside pwm mode the counter wraps from its top to zero and goes on.
// R16: a software write to the counter replaces the count at once.
////////////////////////////////////////////////////////////////////////////////
package tcr_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] TCR_IDX_RELOAD     = 8'hcd;
    localparam logic [7:0] TCR_IDX_AUX_MODE   = 8'hd8;
    localparam logic [7:0] TCR_IDX_UNIT_MODE  = 8'hda;
    localparam logic [7:0] TCR_IDX_COUNT      = 8'hdb;
    localparam logic [7:0] TCR_IDX_IRQ_STATUS = 8'he0;
    localparam logic [7:0] TCR_IDX_IRQ_MASK   = 8'he1;
    localparam logic [7:0] TCR_IDX_APPLIED    = 8'he2;

    // unit mode register fields
    localparam int TCR_MODE_ENABLE_POS  = 7;
    localparam int TCR_MODE_RATE_LSB    = 4;
    localparam int TCR_MODE_SOURCE_POS  = 3;
    localparam int TCR_MODE_RELOAD_POS  = 2;
    localparam int TCR_MODE_TOGGLE_POS  = 1;
    localparam int TCR_MODE_PWM_POS     = 0;

    // aux mode register: only the fast clock select bit exists
    localparam int         TCR_AUX_FAST_POS  = 2;
    localparam logic [7:0] TCR_AUX_VALID     = 8'h04;

    // interrupt status bit
    localparam int TCR_IRQ_OVF_POS = 0;

    // reset values
    localparam logic [7:0] TCR_RST_COUNT  = 8'h00;
    localparam logic [7:0] TCR_RST_RELOAD = 8'h00;
    localparam logic [7:0] TCR_RST_MODE   = 8'h00;
    localparam logic [7:0] TCR_RST_AUX    = 8'h00;

    // overflow boundary masks
    localparam logic [7:0] TCR_MASK_256 = 8'hff;
    localparam logic [7:0] TCR_MASK_64  = 8'h3f;
    localparam logic [7:0] TCR_MASK_32  = 8'h1f;
    localparam logic [7:0] TCR_MASK_16  = 8'h0f;

    // prescale: cpu path divides by 2^(8-code), oscillator path by 2^(7-code)
    localparam logic [3:0] TCR_CPU_DIV_EXP = 4'h8;
    localparam logic [3:0] TCR_OSC_DIV_EXP = 4'h7;

    // avalon response codes
    localparam logic [1:0] TCR_RESP_OK    = 2'h0;
    localparam logic [1:0] TCR_RESP_ERROR = 2'h2;

endpackage

// ===== core/tcr_prescaler.sv
module tcr_prescaler #(
    parameter int DIV_WIDTH = 8
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic       fcpu_tick_in,
    input  wire logic       fosc_tick_in,
    input  wire logic       fast_clock_select_in,
    input  wire logic [2:0] prescale_select_in,
    output logic            count_tick_out
);
    import tcr_pkg::*;

    generate
        if (DIV_WIDTH < 8) begin : g_bad_width
            $error("tcr_prescaler: DIV_WIDTH must be at least 8");
        end
    endgenerate

    typedef struct packed {
        logic [DIV_WIDTH-1:0] div;
        logic                 tick;
    } tcr_pre_s;

    tcr_pre_s st_reg;
    tcr_pre_s st_next;

    logic                 src_tick;
    logic [3:0]           div_exp;
    logic [DIV_WIDTH-1:0] div_mask;

    always_comb begin
        st_next  = st_reg;
        src_tick = fast_clock_select_in ? fosc_tick_in : fcpu_tick_in;                 // R01 R02
        div_exp  = (fast_clock_select_in ? TCR_OSC_DIV_EXP : TCR_CPU_DIV_EXP) - {1'b0, prescale_select_in}; // R01 R02
        div_mask = DIV_WIDTH'((1 << div_exp) - 1);
        st_next.tick = 1'b0;
        if (!run_in) begin
            // a stopped timer restarts with a full first prescale period
            st_next.div = '0;
        end else if (src_tick) begin
            st_next.div = st_reg.div + 1'b1;
            if ((st_reg.div & div_mask) == div_mask) begin
                st_next.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_tick_out = st_reg.tick;

endmodule

// ===== core/tcr_core.sv
module tcr_core (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // avalon-mm slave, byte addressed
    input  wire logic [9:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [1:0]  avs_response_out,
    // count clock sources: cpu and osc ticks are one-cycle enables, the external input counts falling edges
    input  wire logic        fcpu_tick_in,
    input  wire logic        fosc_tick_in,
    input  wire logic        external_event_input_in,
    // events
    output logic             overflow_out,
    output logic             irq_out
);
    import tcr_pkg::*;

    typedef struct packed {
        logic [7:0]  count_value;
        logic [7:0]  reload_hold;
        logic [7:0]  reload_applied;
        logic [7:0]  unit_mode;
        logic [7:0]  aux_mode;
        logic [7:0]  irq_status;
        logic [7:0]  irq_mask;
        logic        ext_prev;
        logic        wait_req;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        overflow;
        logic        irq;
    } tcr_core_s;

    tcr_core_s st_reg;
    tcr_core_s st_next;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    logic       enable;
    logic [2:0] prescale_select;
    logic       source_select;
    logic       reload_control;
    logic       toggle_output_control;
    logic       pwm_enable_bit;
    logic       fast_clock_select;
    logic       auto_reload;
    logic [7:0] bound_mask;

    always_comb begin
        enable                = st_reg.unit_mode[TCR_MODE_ENABLE_POS];
        prescale_select       = st_reg.unit_mode[TCR_MODE_RATE_LSB +: 3];
        source_select         = st_reg.unit_mode[TCR_MODE_SOURCE_POS];
        reload_control        = st_reg.unit_mode[TCR_MODE_RELOAD_POS];
        toggle_output_control = st_reg.unit_mode[TCR_MODE_TOGGLE_POS];
        pwm_enable_bit        = st_reg.unit_mode[TCR_MODE_PWM_POS];
        fast_clock_select     = st_reg.aux_mode[TCR_AUX_FAST_POS];
        auto_reload           = reload_control || pwm_enable_bit;              // R09 R11
        bound_mask            = TCR_MASK_256;                                  // R05
        if (pwm_enable_bit && !source_select) begin                            // R14
            case ({reload_control, toggle_output_control})                     // R06
                2'b00:   bound_mask = TCR_MASK_256;
                2'b01:   bound_mask = TCR_MASK_64;
                2'b10:   bound_mask = TCR_MASK_32;
                2'b11:   bound_mask = TCR_MASK_16;
                default: bound_mask = TCR_MASK_256;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count clock

    logic prescale_tick;

    tcr_prescaler #(
        .DIV_WIDTH(8)
    ) u_prescaler (
        .sys_clk_in           (sys_clk_in),
        .rst_in               (rst_in),
        .run_in               (enable && !source_select),
        .fcpu_tick_in         (fcpu_tick_in),
        .fosc_tick_in         (fosc_tick_in),
        .fast_clock_select_in (fast_clock_select),
        .prescale_select_in   (prescale_select),
        .count_tick_out       (prescale_tick)
    );

    logic ext_fall;
    logic count_tick;
    logic at_top;
    logic ovf_event;

    always_comb begin
        ext_fall   = st_reg.ext_prev && !external_event_input_in;              // R13
        // the prescaler output is simply not looked at in event mode
        count_tick = enable && (source_select ? ext_fall : prescale_tick);    // R03 R13
        at_top     = (st_reg.count_value & bound_mask) == bound_mask;
        ovf_event  = count_tick && at_top;                                     // R05 R06
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic       req;
    logic       accept;
    logic       lane0;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] wbyte;
    logic       wr_reload;
    logic       wr_unit_mode;
    logic       wr_aux;
    logic       wr_count;
    logic       wr_status;
    logic       wr_mask;
    logic [7:0] rd_byte;

    always_comb begin
        req    = avs_read_in || avs_write_in;
        // a write takes effect only on the edge where waitrequest is seen low
        accept = req && !st_reg.wait_req;
        lane0  = avs_byteenable_in[0];
        idx    = avs_address_in[9:2];
        wbyte  = avs_writedata_in[7:0];
        mapped = (avs_address_in[1:0] == 2'h0)
              && (idx == TCR_IDX_RELOAD || idx == TCR_IDX_AUX_MODE || idx == TCR_IDX_UNIT_MODE
               || idx == TCR_IDX_COUNT || idx == TCR_IDX_IRQ_STATUS || idx == TCR_IDX_IRQ_MASK
               || idx == TCR_IDX_APPLIED);
        wr_reload    = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_RELOAD;
        wr_aux       = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_AUX_MODE;
        wr_unit_mode = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_UNIT_MODE;
        wr_count     = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_COUNT;
        wr_status    = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_IRQ_STATUS;
        wr_mask      = accept && avs_write_in && lane0 && mapped && idx == TCR_IDX_IRQ_MASK;
        case (idx)
            TCR_IDX_AUX_MODE:   rd_byte = st_reg.aux_mode & TCR_AUX_VALID;
            TCR_IDX_UNIT_MODE:  rd_byte = st_reg.unit_mode;
            TCR_IDX_COUNT:      rd_byte = st_reg.count_value;                  // R04
            TCR_IDX_IRQ_STATUS: rd_byte = st_reg.irq_status;
            TCR_IDX_IRQ_MASK:   rd_byte = st_reg.irq_mask;
            TCR_IDX_APPLIED:    rd_byte = st_reg.reload_applied;
            // reload is write only and reads as zero
            default:            rd_byte = 8'h00;
        endcase
        if (avs_address_in[1:0] != 2'h0) begin
            rd_byte = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next          = st_reg;
        st_next.ext_prev = external_event_input_in;
        st_next.overflow = ovf_event;                                          // R12

        // bus handshake: one wait cycle, then the answer
        // waitrequest idles high and drops for exactly the answer cycle
        st_next.wait_req = !(req && st_reg.wait_req);
        if (req && st_reg.wait_req) begin
            st_next.rdata = avs_read_in ? {24'h000000, rd_byte} : 32'h00000000;
            st_next.resp  = mapped ? TCR_RESP_OK : TCR_RESP_ERROR;
        end

        if (wr_unit_mode) begin
            st_next.unit_mode = wbyte;
        end
        if (wr_aux) begin
            st_next.aux_mode = wbyte & TCR_AUX_VALID;
        end
        if (wr_mask) begin
            st_next.irq_mask = wbyte;
        end
        if (wr_reload) begin
            st_next.reload_hold = wbyte;                                       // R10
        end

        // counter
        if (ovf_event) begin
            st_next.reload_applied = st_reg.reload_hold;                       // R10
            if (auto_reload) begin
                st_next.count_value = st_reg.reload_hold & bound_mask;         // R09 R11 R07
            end else begin
                st_next.count_value = 8'h00;                                   // R15
            end
        end else if (count_tick) begin
            st_next.count_value = (st_reg.count_value + 8'h01) & bound_mask;   // R07
        end
        if (wr_count) begin
            // software write overrides the tick of the same cycle
            st_next.count_value = wbyte & bound_mask;                          // R16 R07
        end

        // sticky status, set wins over a write-one clear
        if (wr_status) begin
            st_next.irq_status = st_reg.irq_status & ~wbyte;
        end
        if (ovf_event) begin
            st_next.irq_status[TCR_IRQ_OVF_POS] = 1'b1;                        // R12
        end
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg                <= '0;
            st_reg.count_value    <= TCR_RST_COUNT;                            // R04
            st_reg.reload_hold    <= TCR_RST_RELOAD;
            st_reg.reload_applied <= TCR_RST_RELOAD;
            st_reg.unit_mode      <= TCR_RST_MODE;
            st_reg.aux_mode       <= TCR_RST_AUX;
            st_reg.wait_req       <= 1'b1;
            st_reg.resp           <= TCR_RESP_OK;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        avs_readdata_out    = st_reg.rdata;
        avs_waitrequest_out = st_reg.wait_req;
        avs_response_out    = st_reg.resp;
        overflow_out        = st_reg.overflow;
        irq_out             = st_reg.irq;
    end

endmodule

// ===== test/tcr_core_props.sv
module tcr_core_props
    import tcr_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic [9:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [1:0]  avs_response_out,
    input wire logic        fcpu_tick_in,
    input wire logic        fosc_tick_in,
    input wire logic        external_event_input_in,
    input wire logic        overflow_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    sequence taken_s;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence answer_s;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    sequence rd_at_s(logic [7:0] idx);
        taken_s ##0 avs_read_in && avs_address_in == {idx, 2'b00};
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_wait_one_cycle: assert property (taken_s |=> answer_s)
        else $error("waitrequest answer not one cycle");
    chk_idle_wait_high: assert property (!(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
        else $error("waitrequest low while idle");
    chk_misaligned_error: assert property (taken_s ##0 avs_address_in[1:0] != 2'h0 |=>
        avs_response_out == TCR_RESP_ERROR && avs_readdata_out == 32'h0)
        else $error("misaligned access not refused");
    chk_read_width: assert property (avs_readdata_out[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_reload_write_only: assert property (rd_at_s(TCR_IDX_RELOAD) |=>
        avs_readdata_out == 32'h0 && avs_response_out == TCR_RESP_OK)
        else $error("reload value readable");
    chk_count_read_ok: assert property (rd_at_s(TCR_IDX_COUNT) |=> avs_response_out == TCR_RESP_OK)
        else $error("count read refused");
    // irq may only rise from a fresh overflow or a register write (mask)
    chk_irq_cause: assert property ($rose(irq_out) |-> overflow_out || $past(avs_write_in))
        else $error("irq rose without cause");
    chk_ovf_source: assert property (overflow_out |-> $past(fcpu_tick_in, 2) || $past(fosc_tick_in, 2)
        || ($past(external_event_input_in, 2) && !$past(external_event_input_in)))
        else $error("overflow without count source");
endmodule

bind tcr_core tcr_core_props tcr_core_props_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .fcpu_tick_in(fcpu_tick_in), .fosc_tick_in(fosc_tick_in),
    .external_event_input_in(external_event_input_in), .overflow_out(overflow_out), .irq_out(irq_out));

// ===== test/tcr_core_bench.sv
module tcr_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import tcr_pkg::*;
    logic        clk, rst, rd, wr, fcpu, fosc, ext, wt, ovf, irq;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  resp;
    logic [3:0]  be;
    logic [7:0]  exp_q[$];
    logic [31:0] rnd;
    int          fails, samples_checked, ovf_seen;

    tcr_core tcr_core_i (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wt), .avs_response_out(resp), .fcpu_tick_in(fcpu), .fosc_tick_in(fosc),
        .external_event_input_in(ext), .overflow_out(ovf), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until waitrequest is seen low, released by nba at that edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wt !== 1'b0 && k < 40);
        if (k >= 40) begin
            fails++;
            test_done();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wrr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic rdr(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, {idx, 2'b00}, 8'h00);
    endtask
    // src 0 cpu, 1 osc, 2 external; the unselected sources get noise that must be ignored
    task automatic run(input logic [7:0] m, input logic [7:0] ax, input logic [7:0] c, input int n,
                       input int src);
        wrr(TCR_IDX_UNIT_MODE, m & 8'h7f);
        wrr(TCR_IDX_AUX_MODE, ax);
        wrr(TCR_IDX_COUNT, c);
        wrr(TCR_IDX_UNIT_MODE, m);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            fcpu <= (src == 0) ? 1'b1 : rnd[0];
            fosc <= (src == 1) ? 1'b1 : rnd[1];
            ext <= (src == 2) ? 1'b1 : rnd[2];
            if (src == 2) begin
                @(posedge clk);
                ext <= 1'b0;
            end
        end
        @(posedge clk);
        fcpu <= 1'b0;
        fosc <= 1'b0;
        ext <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rd === 1'b1 && wt === 1'b0 && exp_q.size() > 0) begin
            chk("readdata", {24'h0, exp_q.pop_front()}, rdata);
        end
        if (ovf === 1'b1) begin
            ovf_seen++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #400000;
        fails++;
        test_done();
    end
    initial begin
        logic [7:0] st;
        logic [7:0] ridx[7] = '{TCR_IDX_RELOAD, TCR_IDX_AUX_MODE, TCR_IDX_UNIT_MODE, TCR_IDX_COUNT,
                                TCR_IDX_IRQ_STATUS, TCR_IDX_IRQ_MASK, TCR_IDX_APPLIED};
        logic [7:0] msk[4] = '{8'hff, 8'h3f, 8'h1f, 8'h0f};
        {rd, wr, fcpu, fosc, ext, addr, wdata, fails, samples_checked, ovf_seen} = '0;
        be = 4'hf;
        rnd = 32'h47bf;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ridx[i]) rdr(ridx[i], 8'h00);
        rdr(8'h10, 8'h00);
        chk("response", {30'h0, TCR_RESP_ERROR}, {30'h0, resp});
        bus(1'b1, {TCR_IDX_COUNT, 2'b01}, 8'h55);
        chk("response", {30'h0, TCR_RESP_ERROR}, {30'h0, resp});
        rdr(TCR_IDX_COUNT, 8'h00);
        chk("response", {30'h0, TCR_RESP_OK}, {30'h0, resp});
        wrr(TCR_IDX_AUX_MODE, 8'hff);
        rdr(TCR_IDX_AUX_MODE, 8'h04);
        wrr(TCR_IDX_COUNT, 8'ha5);
        // lane 0 off: this write must not land
        be <= 4'he;
        wrr(TCR_IDX_COUNT, 8'h3c);
        be <= 4'hf;
        rdr(TCR_IDX_COUNT, 8'ha5);
        wrr(TCR_IDX_RELOAD, 8'h40);
        rdr(TCR_IDX_RELOAD, 8'h00);
        rdr(TCR_IDX_APPLIED, 8'h00);
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                rnd = lfsr(rnd);
                st = rnd[7:0] & 8'h7f;
                run(8'h80 | 8'(c << 4), f ? 8'h04 : 8'h00, st, 3 * (f ? (1 << (7 - c)) : (1 << (8 - c))), f);
                rdr(TCR_IDX_COUNT, st + 8'h03);
            end
        end
        run(8'hf4, 8'h00, 8'(256 - 1), 2, 0);
        rdr(TCR_IDX_COUNT, 8'h40);
        rdr(TCR_IDX_APPLIED, 8'h40);
        rdr(TCR_IDX_IRQ_STATUS, 8'h01);
        chk("overflow pulses", 32'd1, ovf_seen);
        wrr(TCR_IDX_IRQ_MASK, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wrr(TCR_IDX_IRQ_STATUS, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        run(8'hf0, 8'h00, 8'hff, 2, 0);
        rdr(TCR_IDX_COUNT, 8'h00);
        wrr(TCR_IDX_RELOAD, 8'ha5);
        for (int b = 0; b < 4; b++) begin
            run(8'hf1 | 8'(b << 1), 8'h00, 8'hff, 0, 0);
            rdr(TCR_IDX_COUNT, msk[b]);
            run(8'hf1 | 8'(b << 1), 8'h00, 8'hff, 2, 0);
            rdr(TCR_IDX_COUNT, 8'ha5 & msk[b]);
        end
        run(8'hbf, 8'h04, 8'h0f, 3, 2);
        rdr(TCR_IDX_COUNT, 8'h12);
        chk("overflow pulses", 32'd6, ovf_seen);
        test_done();
    end
endmodule
